// [rtl/shared_pin_interface.sv]
// Shared address and data pin logic for the DRAM and static bus controllers.
`timescale 1ns/100ps
module shared_pin_interface
    import shared_pin_pkg::*;
(
    input wire logic clock,                         // System clock, 25 MHz.
    input wire logic reset,                         // Synchronous reset, active high.
    input wire dram_req_s dram_req,                 // DRAM controller request.
    input wire static_req_s static_req,             // Static bus controller request.
    output logic dram_grant,                        // DRAM controller owns the pins.
    output logic static_grant,                      // Static controller owns the pins.
    output logic [DATA_W-1:0] rdata,                // Captured read data.
    output logic [ADDR_W-1:0] strap_value,          // Address straps held at reset.
    output logic strap_bit_ten,                     // Test strap from bit-ten pin.
    input wire logic [ADDR_W-1:0] addr_in,          // Address pins, input side.
    output logic [ADDR_W-1:0] addr_out,             // Address pins, output side.
    output logic addr_oe_n,                         // Address pin enable, low drives.
    input wire logic dram_addr_bit_ten_pin_in,      // Bit-ten pin, input side.
    output logic dram_addr_bit_ten_pin_out,         // Bit-ten pin, output side.
    output logic dram_addr_bit_ten_pin_oe_n,        // Bit-ten pin enable, low drives.
    input wire logic [DATA_W-1:0] data_in,          // Data pins, input side.
    output logic [DATA_W-1:0] data_out,             // Data pins, output side.
    output logic data_oe_n,                         // Data pin enable, low drives.
    output logic bus_isolate_out                    // High isolates non-DRAM devices.
);

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    logic [ADDR_W-1:0] addr_meta_reg;
    logic [ADDR_W-1:0] addr_sync_reg;
    logic ten_meta_reg;
    logic ten_sync_reg;
    logic [DATA_W-1:0] data_meta_reg;
    logic [DATA_W-1:0] data_sync_reg;

    always_ff @(posedge clock) begin
        addr_meta_reg <= addr_in;
        addr_sync_reg <= addr_meta_reg;
        ten_meta_reg <= dram_addr_bit_ten_pin_in;
        ten_sync_reg <= ten_meta_reg;
        data_meta_reg <= data_in;
        data_sync_reg <= data_meta_reg;
    end

    // ****************************************
    // Boot straps
    // ****************************************
    // Straps follow the pins while reset holds them as inputs, so the
    // configured state is visible during reset and frozen at release.
    always_ff @(posedge clock) begin
        if (reset) begin
            strap_value <= addr_sync_reg;
            strap_bit_ten <= ten_sync_reg;
        end
    end

    // ****************************************
    // Ownership
    // ****************************************
    owner_e owner_reg;
    owner_e owner_next;
    logic wait_reg;

    // A new owner is taken only from idle, so the controllers never overlap.
    always_comb begin
        owner_next = owner_reg;
        case (owner_reg)
            OWN_NONE: begin
                if (dram_req.req) begin
                    owner_next = OWN_DRAM;
                end else if (static_req.req) begin
                    owner_next = OWN_STATIC;
                end
            end
            OWN_DRAM: begin
                if (!dram_req.req) begin
                    owner_next = OWN_NONE;
                end
            end
            OWN_STATIC: begin
                if (!static_req.req) begin
                    owner_next = OWN_NONE;
                end
            end
            default: owner_next = OWN_NONE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            owner_reg <= OWN_NONE;
        end else begin
            owner_reg <= owner_next;
        end
    end

    // First cycle after release still holds all pins as inputs.
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= 1'b0;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic [ADDR_W-1:0] static_pin_addr;
    logic [ADDR_W-1:0] dram_pin_addr;

    static_addr_map u_map (
        .width(static_req.width),
        .byte_addr(static_req.byte_addr),
        .pin_addr(static_pin_addr)
    );

    // Pin 15 is unused by DRAM and stays low; bit ten goes out its own pin.
    assign dram_pin_addr = {dram_req.addr[DRAM_ADDR_W-1:DRAM_ADDR_W-4], 1'b0,
        dram_req.addr[ADDR_MID_HI-ADDR_MID_LO:0], 5'h00};

    always_ff @(posedge clock) begin
        if (reset || wait_reg) begin
            addr_oe_n <= OE_N_OFF;
            dram_addr_bit_ten_pin_oe_n <= OE_N_OFF;
            data_oe_n <= OE_N_OFF;
            bus_isolate_out <= ISOLATE_RESET;
            addr_out <= ADDR_RESET;
            dram_addr_bit_ten_pin_out <= BIT_TEN_RESET;
            data_out <= DATA_RESET;
            dram_grant <= 1'b0;
            static_grant <= 1'b0;
        end else begin
            addr_oe_n <= 1'b0;
            dram_addr_bit_ten_pin_oe_n <= 1'b0;
            dram_grant <= (owner_next == OWN_DRAM);
            static_grant <= (owner_next == OWN_STATIC);
            // Isolation is low only while the static controller owns the bus.
            bus_isolate_out <= (owner_next != OWN_STATIC);
            case (owner_next)
                OWN_DRAM: begin
                    addr_out <= dram_pin_addr;
                    dram_addr_bit_ten_pin_out <= dram_req.addr[DRAM_ADDR_W-5];
                    data_out <= dram_req.wdata;
                    data_oe_n <= ~dram_req.write;
                end
                OWN_STATIC: begin
                    addr_out <= static_pin_addr;
                    dram_addr_bit_ten_pin_out <= dram_addr_bit_ten_pin_out;
                    data_out <= static_req.wdata;
                    data_oe_n <= ~static_req.write;
                end
                default: begin
                    addr_out <= addr_out;
                    dram_addr_bit_ten_pin_out <= dram_addr_bit_ten_pin_out;
                    data_out <= data_out;
                    data_oe_n <= OE_N_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata <= DATA_RESET;
        end else if (owner_reg != OWN_NONE && data_oe_n) begin
            rdata <= data_sync_reg;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_reset_inputs: assert property (@(posedge clock) reset |=> addr_oe_n && data_oe_n
        && dram_addr_bit_ten_pin_oe_n) else $error("Pins driven during reset.");
    a_release_hold: assert property (@(posedge clock) $fell(reset) |=> addr_oe_n && bus_isolate_out)
        else $error("Pins driven right after reset release.");
    a_isolate_reset: assert property (@(posedge clock) reset |=> bus_isolate_out)
        else $error("Isolate low during reset.");
    a_one_owner: assert property (@(posedge clock) disable iff (reset) !(dram_grant && static_grant))
        else $error("Both controllers own the pins.");
    a_dram_isolated: assert property (@(posedge clock) disable iff (reset) dram_grant |-> bus_isolate_out)
        else $error("DRAM cycle without isolation.");
    a_static_connect: assert property (@(posedge clock) disable iff (reset)
        static_grant |-> !bus_isolate_out) else $error("Static cycle while isolated.");
    a_addr_driven: assert property (@(posedge clock) disable iff (reset) !$past(reset, 2) |-> !addr_oe_n)
        else $error("Address pins not driven after reset.");
    a_strap_frozen: assert property (@(posedge clock) disable iff (reset) $stable(strap_value))
        else $error("Strap value changed out of reset.");
    a_dram_pin15: assert property (@(posedge clock) disable iff (reset)
        dram_grant |-> !addr_out[ADDR_MID_HI+1]) else $error("Pin 15 used in DRAM cycle.");
    a_grant_drop: assert property (@(posedge clock) disable iff (reset)
        dram_grant && !dram_req.req |=> !dram_grant)
        else $error("DRAM grant held after its request fell.");
    a_isolate_first: assert property (@(posedge clock) disable iff (reset)
        $rose(dram_grant) |-> $past(bus_isolate_out))
        else $error("Isolation not in place before the DRAM cycle.");
    a_data_idle: assert property (@(posedge clock) disable iff (reset)
        !dram_grant && !static_grant |-> data_oe_n)
        else $error("Data pins driven with no owner.");
    a_ten_hold: assert property (@(posedge clock) disable iff (reset)
        static_grant |=> $stable(dram_addr_bit_ten_pin_out))
        else $error("Bit-ten pin moved in a static cycle.");

    // ****************************************
    // Coverage
    // ****************************************
    c_dram_cycle: cover property (@(posedge clock) disable iff (reset) $rose(dram_grant));
    c_static_cycle: cover property (@(posedge clock) disable iff (reset) $rose(static_grant));
    c_handover: cover property (@(posedge clock) disable iff (reset) dram_grant ##[1:4] static_grant);
    c_dram_write: cover property (@(posedge clock) disable iff (reset) dram_grant && !data_oe_n);
    c_reset_release: cover property (@(posedge clock) $fell(reset));

endmodule : shared_pin_interface

// [pkg/shared_pin_pkg.sv]
// Package with constants and carriers for the shared memory bus pin logic.
package shared_pin_pkg;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int DRAM_ADDR_W = 15;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
    localparam logic ISOLATE_RESET = 1'b1;
    localparam logic OE_N_OFF = 1'b1;
    localparam logic BIT_TEN_RESET = 1'b1;
    localparam int ADDR_HIGH_LO = 16;
    localparam int ADDR_MID_LO = 5;
    localparam int ADDR_MID_HI = 14;

    // Static-bus data width of the selected channel.
    typedef enum logic [1:0] {
        WIDTH_32,
        WIDTH_16,
        WIDTH_8
    } bus_width_e;

    // Which controller owns the shared pins.
    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_DRAM,
        OWN_STATIC
    } owner_e;

    // Request from the synchronous DRAM controller.
    typedef struct packed {
        logic req;
        logic write;
        logic [DRAM_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dram_req_s;

    // Request from the static-memory bus controller.
    typedef struct packed {
        logic req;
        logic write;
        bus_width_e width;
        logic [ADDR_W+1:0] byte_addr;
        logic [DATA_W-1:0] wdata;
    } static_req_s;

endpackage : shared_pin_pkg

// [rtl/static_addr_map.sv]
// Maps a static-bus byte address onto the address pins by data bus width.
`timescale 1ns/100ps
module static_addr_map
    import shared_pin_pkg::*;
(
    input wire bus_width_e width,            // Data bus width of the channel.
    input wire logic [ADDR_W+1:0] byte_addr, // Byte address of the access.
    output logic [ADDR_W-1:0] pin_addr       // Value for the address pins.
);

    // The pin meaning shifts with the port width.
    always_comb begin
        case (width)
            WIDTH_32: pin_addr = byte_addr[ADDR_W+1:2];
            WIDTH_16: pin_addr = byte_addr[ADDR_W:1];
            WIDTH_8: pin_addr = byte_addr[ADDR_W-1:0];
            default: pin_addr = byte_addr[ADDR_W+1:2];
        endcase
    end

endmodule : static_addr_map

// [dv/pin_board_model.sv]
// Board model of the shared pins: pull-ups, strap drivers and a memory.
`timescale 1ns/100ps
module pin_board_model
    import shared_pin_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr_out, // Device address drive.
    input wire logic addr_oe_n,             // Low while the device drives.
    input wire logic bit_ten_out,           // Device bit-ten drive.
    input wire logic bit_ten_oe_n,          // Low while the device drives.
    input wire logic [DATA_W-1:0] data_out, // Device data drive.
    input wire logic data_oe_n,             // Low while the device drives.
    input wire logic strap_en,              // Board drives the straps.
    input wire logic [ADDR_W-1:0] strap,    // Strap levels.
    input wire logic mem_en,                // Memory drives read data.
    input wire logic [DATA_W-1:0] mem_data, // Read data from memory.
    output logic [ADDR_W-1:0] addr_pin,     // Resolved address wire.
    output logic bit_ten_pin,               // Resolved bit-ten wire.
    output logic [DATA_W-1:0] data_pin      // Resolved data wire.
);
    // Released pins float to the pull-up level unless a board part drives them.
    assign addr_pin = !addr_oe_n ? addr_out : strap_en ? strap : '1;
    assign bit_ten_pin = !bit_ten_oe_n ? bit_ten_out : 1'b1;
    assign data_pin = !data_oe_n ? data_out : mem_en ? mem_data : '1;
endmodule : pin_board_model

// [dv/testbench.sv]
// Self-checking testbench for the shared address and data pin logic.
`timescale 1ns/100ps
module testbench
    import shared_pin_pkg::*;
;
    logic clock = 0, reset = 1, strap_en = 1, mem_en = 0;
    dram_req_s dram_req = '0;
    static_req_s static_req = '0;
    logic [19:0] strap = '0, addr_pin, addr_out, strap_value;
    logic [31:0] mem_data = '0, data_pin, data_out, rdata;
    logic dram_grant, static_grant, strap_bit_ten, addr_oe_n, bt_pin, bt_out, bt_oe_n, data_oe_n, bus_isolate_out;
    int n_errors = 0, samples_checked = 0;

    // Reference model of the pin mapping; one expected address word is queued per request.
    int exp_q[$];

    function automatic int model_addr(input bit dram, input int w, input int a);
        if (dram)
            return (((a >> 11) & 32'hf) << 16) | ((a & 32'h3ff) << 5);
        return (a >> (2 - w)) & 32'hfffff;
    endfunction : model_addr

    always #20 clock = ~clock;

    shared_pin_interface dut_u (.clock(clock), .reset(reset), .dram_req(dram_req), .static_req(static_req),
        .dram_grant(dram_grant), .static_grant(static_grant), .rdata(rdata), .strap_value(strap_value),
        .strap_bit_ten(strap_bit_ten), .addr_in(addr_pin), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .dram_addr_bit_ten_pin_in(bt_pin), .dram_addr_bit_ten_pin_out(bt_out),
        .dram_addr_bit_ten_pin_oe_n(bt_oe_n), .data_in(data_pin), .data_out(data_out),
        .data_oe_n(data_oe_n), .bus_isolate_out(bus_isolate_out));
    pin_board_model board_u (.addr_out(addr_out), .addr_oe_n(addr_oe_n), .bit_ten_out(bt_out),
        .bit_ten_oe_n(bt_oe_n), .data_out(data_out), .data_oe_n(data_oe_n), .strap_en(strap_en),
        .strap(strap), .mem_en(mem_en), .mem_data(mem_data), .addr_pin(addr_pin), .bit_ten_pin(bt_pin),
        .data_pin(data_pin));

    // ****************************************
    // Checking and reporting
    // ****************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // One access by either controller, with expected pins worked out from the mapping.
    task automatic access(input bit dram, input bit wr, input bus_width_e w, input logic [21:0] a);
        logic [31:0] d;
        int k;
        d = $urandom;
        exp_q.push_back(model_addr(dram, w, a));
        @(posedge clock);
        mem_data <= ~d;
        mem_en <= !wr;
        if (dram)
            dram_req <= '{1'b1, wr, a[14:0], d};
        else
            static_req <= '{1'b1, wr, w, a, d};
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (!(dram ? dram_grant : static_grant) && k < 8);
        repeat (4) @(posedge clock);
        #1;
        check("grant", dram ? dram_grant : static_grant, 1);
        check("other_grant", dram ? static_grant : dram_grant, 0);
        check("addr_out", addr_out, exp_q.pop_front());
        if (dram)
            check("bit_ten_out", bt_out, a[10]);
        check("isolate", bus_isolate_out, dram);
        check("data_oe_n", data_oe_n, !wr);
        if (wr)
            check("data_out", data_out, d);
        else
            check("rdata", rdata, ~d);
        @(posedge clock);
        dram_req <= '0;
        static_req <= '0;
        mem_en <= 0;
        repeat (2) @(posedge clock);
        #1;
        check("grant_off", {dram_grant, static_grant}, 0);
        check("data_off", data_oe_n, 1);
        check("isolate_idle", bus_isolate_out, 1);
    endtask : access

    initial begin
        void'($urandom(76));
        strap = 20'($urandom);
        repeat (5) @(posedge clock);
        #1;
        check("addr_oe_n_rst", addr_oe_n, 1);
        check("bit_ten_oe_n_rst", bt_oe_n, 1);
        check("data_oe_n_rst", data_oe_n, 1);
        check("isolate_rst", bus_isolate_out, 1);
        check("strap_value", strap_value, strap);
        check("strap_bit_ten", strap_bit_ten, 1);
        @(posedge clock);
        reset <= 0;
        @(posedge clock);
        #1;
        check("addr_hold", addr_oe_n, 1);
        check("isolate_hold", bus_isolate_out, 1);
        @(posedge clock);
        strap_en <= 0;
        #1;
        check("addr_driven", addr_oe_n, 0);
        check("bit_ten_driven", bt_oe_n, 0);
        check("strap_frozen", strap_value, strap);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            access(1, i[0], WIDTH_32, 22'($urandom));
            access(0, i[0], bus_width_e'(i % 3), 22'($urandom));
        end
        $display("test accesses done");
        @(posedge clock);
        dram_req <= '{1'b1, 1'b0, 15'h7fff, 32'h0};
        static_req <= '{1'b1, 1'b0, WIDTH_8, 22'h0, 32'h0};
        repeat (2) @(posedge clock);
        #1;
        check("tie_grants", {dram_grant, static_grant}, 2'b10);
        @(posedge clock);
        dram_req <= '0;
        repeat (3) @(posedge clock);
        #1;
        check("handover", {dram_grant, static_grant}, 2'b01);
        check("handover_iso", bus_isolate_out, 0);
        $display("test contention done");
        @(posedge clock);
        static_req <= '0;
        strap_en <= 1;
        strap <= 20'($urandom);
        reset <= 1;
        repeat (6) @(posedge clock);
        #1;
        check("strap_value_again", strap_value, strap);
        check("grants_rst", {dram_grant, static_grant}, 0);
        check("isolate_rst_again", bus_isolate_out, 1);
        check("data_oe_n_rst_again", data_oe_n, 1);
        check("bit_ten_oe_n_again", bt_oe_n, 1);
        @(posedge clock);
        reset <= 0;
        @(posedge clock);
        #1;
        check("addr_hold_again", addr_oe_n, 1);
        check("isolate_hold_again", bus_isolate_out, 1);
        @(posedge clock);
        strap_en <= 0;
        #1;
        check("addr_driven_again", addr_oe_n, 0);
        check("strap_frozen_again", strap_value, strap);
        access(1, 0, WIDTH_32, 22'($urandom));
        $display("test second reset done");
        final_report;
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        final_report;
    end
endmodule : testbench
